/* File: pkg/wbmt_pkg.sv */
// constants shared by the watchdog / bus monitor / timer block
package wbmt_pkg;
   // register indices; byte address is four times the index
   localparam logic [15:0] IDX_RELOAD_HIGH = 16'hF4C0;
   localparam logic [15:0] IDX_RELOAD_LOW = 16'hF4C2;
   localparam logic [15:0] IDX_COUNT_HIGH = 16'hF4C4;
   localparam logic [15:0] IDX_COUNT_LOW = 16'hF4C6;
   localparam logic [15:0] IDX_CLEAR_KEY = 16'hF4C8;
   localparam logic [15:0] IDX_STATUS = 16'hF4CA;

   // status register fields
   localparam int STAT_CLKSTOP_BIT = 0;
   localparam int STAT_MON_EN_BIT = 1;
   localparam int STAT_WDOG_EN_BIT = 7;

   // reset values
   localparam logic [31:0] RELOAD_RESET = 32'h0000FFFF;
   localparam logic [31:0] COUNT_RESET = 32'h0000FFFF;

   // unlock keys, both as 16-bit word writes
   localparam logic [15:0] KEY_FIRST = 16'hF01E;
   localparam logic [15:0] KEY_SECOND = 16'h0FE1;
   localparam logic [3:0] WORD_STRB = 4'h3;

   // timeout pulse length in clocks
   localparam int PULSE_CYCLES = 8;

   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // unlock sequence progress
   typedef enum logic {
      KEY_IDLE = 1'b0,
      KEY_HALF = 1'b1
   } wbmt_key_e;
endpackage

/* File: hw/wbmt_top.sv */
// watchdog / bus monitor / general-purpose timer with an AXI4-Lite register slave
`timescale 1ns/1ps

// Operation
// - reset enters timer mode, other modes off
// - counter and reload reset to 0000FFFF, decrement
// - count readable as two halves, undisturbed
// - zero count drives pin eight cycles
// - timer mode reloads cycle after zero
// - reload is 32 bits, high then low
// - timer mode reloads only on timeout
// - strobe in brief bus monitor reloads
// - two keys enter watchdog and reload
// - only exact keys, word size, order
// - unlock sets enable, clears monitor, stop
// - after unlock, status and reload locked
// - repeated unlock reloads the counter
// - strobe reloads and starts, ready stops
// - bus monitor keeps reload and enable writable
// - stop bit freezes unit, clear restarts
// - watchdog mode cannot stop the clock
// - timeout also drives interrupt request line
// - bit 7 read-only watchdog enabled flag
// - bit 1 read/write bus monitor enable
// - bit 0 read/write clock stop
module wbmt_top #(
   parameter int ADDR_W = 18
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // processor bus monitor inputs, same clock
   input wire logic address_strobe_n,
   input wire logic bus_ready_n,
   // timeout outputs
   output logic timeout_output_pin,
   output logic slave_request_line_seven
);
   logic [31:0] reload_q;
   logic [31:0] cnt_q;
   logic wdt_en_q;
   logic mon_en_q;
   logic clkstop_q;
   wbmt_pkg::wbmt_key_e key_q;
   logic bm_run_q;
   logic [2:0] pulse_cnt_q;
   logic pulse_q;
   logic irq_q;
   logic pulse_d;
   logic [2:0] pulse_cnt_d;

   logic [ADDR_W-1:0] awaddr_q;
   logic aw_full_q;
   logic awready_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic w_full_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   function automatic logic [15:0] reg_index(input logic [ADDR_W-1:0] addr);
      reg_index = 16'(addr[ADDR_W-1:2]);
   endfunction

   function automatic logic is_mapped(input logic [15:0] idx);
      is_mapped = (idx == wbmt_pkg::IDX_RELOAD_HIGH) || (idx == wbmt_pkg::IDX_RELOAD_LOW) ||
                  (idx == wbmt_pkg::IDX_COUNT_HIGH) || (idx == wbmt_pkg::IDX_COUNT_LOW) ||
                  (idx == wbmt_pkg::IDX_CLEAR_KEY) || (idx == wbmt_pkg::IDX_STATUS);
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                           input logic [1:0] strb);
      merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
   endfunction

   // write decode
   logic wr_go;
   logic [15:0] widx;
   logic wr_word;
   logic hit_rldh;
   logic hit_rldl;
   logic hit_status;
   logic hit_clr;
   logic key_first;
   logic unlock_done;
   assign wr_go = aw_full_q && w_full_q && !bvalid_q;
   assign widx = reg_index(awaddr_q);
   assign wr_word = (wstrb_q == wbmt_pkg::WORD_STRB);
   assign hit_rldh = wr_go && (widx == wbmt_pkg::IDX_RELOAD_HIGH);
   assign hit_rldl = wr_go && (widx == wbmt_pkg::IDX_RELOAD_LOW);
   assign hit_status = wr_go && (widx == wbmt_pkg::IDX_STATUS);
   assign hit_clr = wr_go && (widx == wbmt_pkg::IDX_CLEAR_KEY) && wr_word;
   assign key_first = hit_clr && (wdata_q[15:0] == wbmt_pkg::KEY_FIRST);
   assign unlock_done = hit_clr && (key_q == wbmt_pkg::KEY_HALF) &&
                        (wdata_q[15:0] == wbmt_pkg::KEY_SECOND);

   // mode and count control
   logic gp_mode;
   logic bm_mode;
   logic bm_load;
   logic gp_reload;
   logic dec_w;
   logic zero_hit;
   assign gp_mode = !wdt_en_q && !mon_en_q;
   assign bm_mode = mon_en_q && !wdt_en_q;
   assign bm_load = bm_mode && !clkstop_q && !address_strobe_n && !unlock_done;
   assign gp_reload = gp_mode && !clkstop_q && (cnt_q == 32'h0) && !unlock_done;
   assign dec_w = !clkstop_q && !unlock_done && !bm_load && (cnt_q != 32'h0) &&
                  (!bm_mode || bm_run_q);
   assign zero_hit = dec_w && (cnt_q == 32'h1);

   // write address channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         awready_q <= 1'b0;
         awaddr_q <= '0;
      end else if (s_axi_awvalid && awready_q) begin
         aw_full_q <= 1'b1;
         awready_q <= 1'b0;
         awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_full_q <= 1'b0;
         awready_q <= 1'b1;
      end else begin
         awready_q <= !aw_full_q;
      end
   end

   // write data channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_q <= 1'b0;
         wready_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (s_axi_wvalid && wready_q) begin
         w_full_q <= 1'b1;
         wready_q <= 1'b0;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
         w_full_q <= 1'b0;
         wready_q <= 1'b1;
      end else begin
         wready_q <= !w_full_q;
      end
   end

   // write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= wbmt_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q <= is_mapped(widx) ? wbmt_pkg::RESP_OKAY : wbmt_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // read channel; count halves are sampled without side effects
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= wbmt_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rresp_q <= is_mapped(reg_index(s_axi_araddr)) ? wbmt_pkg::RESP_OKAY
                                                       : wbmt_pkg::RESP_SLVERR;
         case (reg_index(s_axi_araddr))
            wbmt_pkg::IDX_RELOAD_HIGH: rdata_q <= {16'h0000, reload_q[31:16]};
            wbmt_pkg::IDX_RELOAD_LOW: rdata_q <= {16'h0000, reload_q[15:0]};
            wbmt_pkg::IDX_COUNT_HIGH: rdata_q <= {16'h0000, cnt_q[31:16]};
            wbmt_pkg::IDX_COUNT_LOW: rdata_q <= {16'h0000, cnt_q[15:0]};
            wbmt_pkg::IDX_STATUS: begin
               rdata_q <= 32'h0;
               rdata_q[wbmt_pkg::STAT_WDOG_EN_BIT] <= wdt_en_q;
               rdata_q[wbmt_pkg::STAT_MON_EN_BIT] <= mon_en_q;
               rdata_q[wbmt_pkg::STAT_CLKSTOP_BIT] <= clkstop_q;
            end
            default: rdata_q <= 32'h0;
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end else begin
         arready_q <= !rvalid_q;
      end
   end

   // unlock sequence tracker; any write other than a first key breaks the pair
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         key_q <= wbmt_pkg::KEY_IDLE;
      end else if (wr_go) begin
         case (key_q)
            wbmt_pkg::KEY_IDLE: key_q <= key_first ? wbmt_pkg::KEY_HALF : wbmt_pkg::KEY_IDLE;
            wbmt_pkg::KEY_HALF: key_q <= key_first ? wbmt_pkg::KEY_HALF : wbmt_pkg::KEY_IDLE;
            default: key_q <= wbmt_pkg::KEY_IDLE;
         endcase
      end
   end

   // status register; only reset clears the enable flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdt_en_q <= 1'b0;
         mon_en_q <= 1'b0;
         clkstop_q <= 1'b0;
      end else if (unlock_done) begin
         wdt_en_q <= 1'b1;
         mon_en_q <= 1'b0;
         clkstop_q <= 1'b0;
      end else if (hit_status && !wdt_en_q && wstrb_q[0]) begin
         mon_en_q <= wdata_q[wbmt_pkg::STAT_MON_EN_BIT];
         clkstop_q <= wdata_q[wbmt_pkg::STAT_CLKSTOP_BIT];
      end
   end

   // reload value, high and low halves
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reload_q <= wbmt_pkg::RELOAD_RESET;
      end else begin
         if (hit_rldh && !wdt_en_q) begin
            reload_q[31:16] <= merge16(reload_q[31:16], wdata_q[15:0], wstrb_q[1:0]);
         end
         if (hit_rldl && !wdt_en_q) begin
            reload_q[15:0] <= merge16(reload_q[15:0], wdata_q[15:0], wstrb_q[1:0]);
         end
      end
   end

   // bus cycle tracking for monitor mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bm_run_q <= 1'b0;
      end else if (!bm_mode) begin
         bm_run_q <= 1'b0;
      end else if (bm_load) begin
         bm_run_q <= 1'b1;
      end else if (!bus_ready_n && !clkstop_q) begin
         bm_run_q <= 1'b0;
      end
   end

   // down-counter; reload writes never touch it directly
   // loads only at reload events
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= wbmt_pkg::COUNT_RESET;
      end else if (unlock_done) begin
         cnt_q <= reload_q;
      end else if (bm_load) begin
         cnt_q <= reload_q;
      end else if (gp_reload) begin
         cnt_q <= reload_q;
      end else if (dec_w) begin
         cnt_q <= cnt_q - 32'h1;
      end
   end

   // timeout pulse; frozen with the rest of the unit when stopped
   always_comb begin
      pulse_d = pulse_q;
      pulse_cnt_d = pulse_cnt_q;
      if (clkstop_q) begin
         pulse_d = pulse_q;
      end else if (zero_hit) begin
         pulse_d = 1'b1;
         pulse_cnt_d = 3'h0;
      end else if (pulse_q) begin
         pulse_cnt_d = pulse_cnt_q + 3'h1;
         if (pulse_cnt_q == 3'(wbmt_pkg::PULSE_CYCLES - 1)) begin
            pulse_d = 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pulse_q <= 1'b0;
         pulse_cnt_q <= 3'h0;
      end else begin
         pulse_q <= pulse_d;
         pulse_cnt_q <= pulse_cnt_d;
      end
   end

   // internal request copy; a level, so the controller must edge-trigger
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= pulse_d;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign timeout_output_pin = pulse_q;
   assign slave_request_line_seven = irq_q;

   property p_reset_mode;
      @(posedge aclk) !aresetn |=> (!wdt_en_q && !mon_en_q && !clkstop_q &&
         cnt_q == wbmt_pkg::COUNT_RESET && reload_q == wbmt_pkg::RELOAD_RESET);
   endproperty
   a_reset_mode: assert property (p_reset_mode) else $error("reset state wrong");

   property p_decrement;
      @(posedge aclk) disable iff (!aresetn) dec_w |=> cnt_q == $past(cnt_q) - 32'h1;
   endproperty
   a_decrement: assert property (p_decrement) else $error("count did not decrement");

   property p_pulse_len;
      @(posedge aclk) disable iff (!aresetn)
         zero_hit ##1 (!clkstop_q && !zero_hit)[*8] |=> !timeout_output_pin;
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("pulse not eight cycles");

   property p_pulse_high;
      @(posedge aclk) disable iff (!aresetn)
         (zero_hit && !clkstop_q) |=> timeout_output_pin[*8];
   endproperty
   a_pulse_high: assert property (p_pulse_high) else $error("pulse dropped early");

   property p_gp_reload;
      @(posedge aclk) disable iff (!aresetn) gp_reload |=> cnt_q == $past(reload_q);
   endproperty
   a_gp_reload: assert property (p_gp_reload) else $error("timer mode reload missed");

   property p_reload_write_isolated;
      @(posedge aclk) disable iff (!aresetn)
         ((hit_rldh || hit_rldl) && dec_w) |=> cnt_q == $past(cnt_q) - 32'h1;
   endproperty
   a_reload_write_isolated: assert property (p_reload_write_isolated)
      else $error("reload write moved count");

   property p_unlock;
      @(posedge aclk) disable iff (!aresetn)
         unlock_done |=> (wdt_en_q && !mon_en_q && !clkstop_q && cnt_q == $past(reload_q));
   endproperty
   a_unlock: assert property (p_unlock) else $error("unlock effects wrong");

   property p_locked;
      @(posedge aclk) disable iff (!aresetn)
         (wdt_en_q && wr_go) |=> ($stable(reload_q) && !mon_en_q && !clkstop_q && wdt_en_q);
   endproperty
   a_locked: assert property (p_locked) else $error("locked register changed");

   property p_bm_strobe;
      @(posedge aclk) disable iff (!aresetn)
         bm_load |=> (cnt_q == $past(reload_q) && bm_run_q);
   endproperty
   a_bm_strobe: assert property (p_bm_strobe) else $error("strobe did not reload");

   property p_stop_freeze;
      @(posedge aclk) disable iff (!aresetn)
         (clkstop_q && !unlock_done) |=> ($stable(cnt_q) && $stable(timeout_output_pin));
   endproperty
   a_stop_freeze: assert property (p_stop_freeze) else $error("stopped unit moved");

   property p_irq_pin;
      @(posedge aclk) disable iff (!aresetn) slave_request_line_seven == timeout_output_pin;
   endproperty
   a_irq_pin: assert property (p_irq_pin) else $error("request line differs from pin");
endmodule

/* File: bench/wbmt_cpu_model.sv */
// processor bus and interrupt controller model facing the timer block
`timescale 1ns/1ps
module wbmt_cpu_model (
   // clock
   input wire logic aclk,
   // processor bus, idle high
   output logic address_strobe_n,
   output logic bus_ready_n,
   // interrupt request from the timer
   input wire logic slave_request_line_seven,
   output int irq_edges
);
   logic irq_q = 1'b0;

   initial begin
      address_strobe_n = 1'b1;
      bus_ready_n = 1'b1;
      irq_edges = 0;
   end

   always @(posedge aclk) begin
      irq_q <= slave_request_line_seven;
      if (slave_request_line_seven && !irq_q) begin
         irq_edges <= irq_edges + 1;
      end
   end

   // one bus cycle: strobe for a clock, ws wait states, then ready unless the cycle hangs
   task automatic bus_cycle(input int ws, input bit give_ready);
      @(posedge aclk);
      address_strobe_n <= 1'b0;
      @(posedge aclk);
      address_strobe_n <= 1'b1;
      repeat (ws) @(posedge aclk);
      if (give_ready) begin
         bus_ready_n <= 1'b0;
      end
      @(posedge aclk);
      bus_ready_n <= 1'b1;
   endtask
endmodule

/* File: bench/testbench.sv */
// self-checking testbench of the watchdog / bus monitor / timer block
`timescale 1ns/1ps
module testbench;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [17:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat, a, b, rv, rv2;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, bresp_q, rresp_q;
   logic address_strobe_n, bus_ready_n, timeout_output_pin, slave_request_line_seven;
   int n_mismatch = 0, check_count = 0, cyc = 0, hi_len = 0, rcyc, ca, irq_edges, ws, n;
   int rises[$];
   logic pin_q = 1'b0;
   logic [31:0] seed = 32'hF2B2;
   logic [15:0] bad[4][4] = '{'{16'hF01E, 16'hF, 16'h0FE1, 16'h3},
      '{16'hF01E, 16'h3, 16'h0FE1, 16'h1}, '{16'h0FE1, 16'h3, 16'hF01E, 16'h3},
      '{16'hF01E, 16'h3, 16'h0FE2, 16'h3}};

   wbmt_top #(.ADDR_W(18)) i_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .address_strobe_n(address_strobe_n),
      .bus_ready_n(bus_ready_n), .timeout_output_pin(timeout_output_pin),
      .slave_request_line_seven(slave_request_line_seven));

   wbmt_cpu_model i_cpu (.aclk(aclk), .address_strobe_n(address_strobe_n),
      .bus_ready_n(bus_ready_n), .slave_request_line_seven(slave_request_line_seven),
      .irq_edges(irq_edges));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic summarize();
      if (n_mismatch == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic timed_out();
      n_mismatch++;
      $display("Error at %0t ns: wait ran out", $time);
      summarize();
   endtask

   // pulse start cycles, pulse widths and the request line
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      pin_q <= timeout_output_pin;
      if (timeout_output_pin && !pin_q) rises.push_back(cyc);
      check({31'h0, slave_request_line_seven}, {31'h0, timeout_output_pin});
      if (!aresetn) begin
         hi_len <= 0;
      end else if (timeout_output_pin) begin
         hi_len <= hi_len + 1;
      end else if (hi_len != 0) begin
         check(32'(hi_len), 32'h8);
         hi_len <= 0;
      end
   end

   task automatic wr(input logic [15:0] idx, input logic [15:0] d, input logic [3:0] st);
      int k;
      @(posedge aclk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {16'h0, d};
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            bresp_q = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
      if (k == 100) timed_out();
   endtask

   task automatic rd(input logic [15:0] idx);
      int k;
      @(posedge aclk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            rcyc = cyc;
         end
         if (s_axi_rvalid) begin
            rdat = s_axi_rdata;
            rresp_q = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
      if (k == 100) timed_out();
   endtask

   task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
      rd(idx);
      check(rdat, exp);
   endtask

   task automatic wait_rises(input int cnt);
      int k;
      for (k = 0; k < 1000 && rises.size() < cnt; k++) @(posedge aclk);
      if (k == 1000) timed_out();
   endtask

   task automatic unlock();
      wr(wbmt_pkg::IDX_CLEAR_KEY, wbmt_pkg::KEY_FIRST, wbmt_pkg::WORD_STRB);
      wr(wbmt_pkg::IDX_CLEAR_KEY, wbmt_pkg::KEY_SECOND, wbmt_pkg::WORD_STRB);
   endtask

   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(wbmt_pkg::IDX_RELOAD_HIGH, 32'h0);
      rdc(wbmt_pkg::IDX_RELOAD_LOW, 32'hFFFF);
      rdc(wbmt_pkg::IDX_STATUS, 32'h0);
      rdc(wbmt_pkg::IDX_COUNT_HIGH, 32'h0);
      rd(wbmt_pkg::IDX_COUNT_LOW);
      a = rdat;
      ca = rcyc;
      rd(wbmt_pkg::IDX_COUNT_LOW);
      check(rdat, a - 32'(rcyc - ca));
      rd(16'hF4CC);
      check({30'h0, rresp_q}, {30'h0, wbmt_pkg::RESP_SLVERR});
      wr(16'hF4CC, 16'h1, 4'h1);
      check({30'h0, bresp_q}, {30'h0, wbmt_pkg::RESP_SLVERR});
      wr(wbmt_pkg::IDX_COUNT_HIGH, 16'h1234, 4'h3);
      rdc(wbmt_pkg::IDX_COUNT_HIGH, 32'h0);
      rv = 32'd20 + (rnd() % 64);
      rv2 = 32'd20 + (rnd() % 64);
      wr(wbmt_pkg::IDX_RELOAD_LOW, rv[15:0], 4'h3);
      wr(wbmt_pkg::IDX_STATUS, 16'h2, 4'h1);
      i_cpu.bus_cycle(0, 1'b0);
      wr(wbmt_pkg::IDX_STATUS, 16'h0, 4'h1);
      rd(wbmt_pkg::IDX_COUNT_LOW);
      check({31'h0, rdat <= rv && rdat + 20 > rv}, 32'h1);
      n = rises.size();
      wait_rises(n + 2);
      wr(wbmt_pkg::IDX_RELOAD_LOW, rv2[15:0], 4'h3);
      wait_rises(n + 4);
      check(32'(rises[n + 2] - rises[n + 1]), rv + 1);
      check(32'(rises[n + 3] - rises[n + 2]), rv2 + 1);
      // let the pulse end first: a stop would freeze it high
      repeat (12) @(posedge aclk);
      wr(wbmt_pkg::IDX_STATUS, 16'h1, 4'h1);
      rdc(wbmt_pkg::IDX_STATUS, 32'h1);
      rd(wbmt_pkg::IDX_COUNT_LOW);
      a = rdat;
      rdc(wbmt_pkg::IDX_COUNT_LOW, a);
      wr(wbmt_pkg::IDX_STATUS, 16'h0, 4'h1);
      rd(wbmt_pkg::IDX_COUNT_LOW);
      a = rdat;
      rd(wbmt_pkg::IDX_COUNT_LOW);
      check({31'h0, rdat !== a}, 32'h1);
      wr(wbmt_pkg::IDX_STATUS, 16'h2, 4'h1);
      rv = 32'd40 + (rnd() % 32);
      wr(wbmt_pkg::IDX_RELOAD_LOW, rv[15:0], 4'h3);
      rdc(wbmt_pkg::IDX_RELOAD_LOW, rv);
      // counter is halted here, so a large high half does no harm
      b = rnd();
      wr(wbmt_pkg::IDX_RELOAD_HIGH, b[15:0], 4'h3);
      rdc(wbmt_pkg::IDX_RELOAD_HIGH, {16'h0, b[15:0]});
      wr(wbmt_pkg::IDX_RELOAD_HIGH, 16'h0, 4'h3);
      rdc(wbmt_pkg::IDX_STATUS, 32'h2);
      // bus cycle kept shorter than the reload value
      ws = 5 + int'(rnd() % 10);
      i_cpu.bus_cycle(ws, 1'b1);
      rd(wbmt_pkg::IDX_COUNT_LOW);
      a = rdat;
      check({31'h0, a == rv - ws || a == rv - ws - 1}, 32'h1);
      rdc(wbmt_pkg::IDX_COUNT_LOW, a);
      n = rises.size();
      i_cpu.bus_cycle(0, 1'b0);
      wait_rises(n + 1);
      repeat (12) @(posedge aclk);
      rdc(wbmt_pkg::IDX_COUNT_LOW, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wr(wbmt_pkg::IDX_CLEAR_KEY, bad[i][0], bad[i][1][3:0]);
         wr(wbmt_pkg::IDX_CLEAR_KEY, bad[i][2], bad[i][3][3:0]);
      end
      rdc(wbmt_pkg::IDX_STATUS, 32'h2);
      rv = 32'd60 + (rnd() % 64);
      wr(wbmt_pkg::IDX_RELOAD_LOW, rv[15:0], 4'h3);
      wr(wbmt_pkg::IDX_STATUS, 16'h3, 4'h1);
      unlock();
      rdc(wbmt_pkg::IDX_STATUS, 32'h80);
      rd(wbmt_pkg::IDX_COUNT_LOW);
      check({31'h0, rdat <= rv && rdat + 20 > rv}, 32'h1);
      wr(wbmt_pkg::IDX_STATUS, 16'h1, 4'h1);
      wr(wbmt_pkg::IDX_RELOAD_LOW, 16'h5, 4'h3);
      rdc(wbmt_pkg::IDX_STATUS, 32'h80);
      rdc(wbmt_pkg::IDX_RELOAD_LOW, rv);
      repeat (10) @(posedge aclk);
      unlock();
      rd(wbmt_pkg::IDX_COUNT_LOW);
      check({31'h0, rdat <= rv && rdat + 20 > rv}, 32'h1);
      n = rises.size();
      wait_rises(n + 1);
      repeat (12) @(posedge aclk);
      rdc(wbmt_pkg::IDX_COUNT_LOW, 32'h0);
      check(32'(irq_edges), 32'(rises.size()));
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(wbmt_pkg::IDX_STATUS, 32'h0);
      rdc(wbmt_pkg::IDX_RELOAD_LOW, 32'hFFFF);
      summarize();
   end
endmodule
